// [design/rscc_if.sv]
`timescale 1ns/1ps
interface rscc_if;
  import rscc_pkg::*;
  logic [1:0] sel;
  logic override_n;
  rscc_speed_t fused;
  rscc_speed_t speed;
  modport ctrl (output sel, output override_n, output fused, input speed);
  modport lim (input sel, input override_n, input fused, output speed);
endinterface

// [design/rscc_pkg.sv]
package rscc_pkg;
  localparam int RSCC_W = 24;
  localparam int RSCC_ADDR_W = 2;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [RSCC_ADDR_W-1:0] RSCC_OFS_CFG = 2'h0;
  // ****************************************
  // field positions
  // ****************************************
  localparam int RSCC_BIT_FLASH8 = 0;
  localparam int RSCC_BIT_HOST = 1;
  localparam int RSCC_BIT_ARB = 2;
  localparam int RSCC_BIT_RSVD3 = 3;
  localparam int RSCC_BIT_PCI66 = 4;
  localparam int RSCC_BIT_SPD_LO = 21;
  localparam int RSCC_BIT_SPD_HI = 22;
  localparam int RSCC_BIT_OVR_N = 23;
  // read-only field: bits 23:21
  localparam logic [23:0] RSCC_RO_MASK = 24'he00000;
  localparam logic [23:0] RSCC_RESET_VAL = 24'hffffff;
  // ****************************************
  // processor speed codes
  // ****************************************
  typedef enum logic [1:0] {
    RSCC_SPD_266 = 2'b00,
    RSCC_SPD_400 = 2'b01,
    RSCC_SPD_533 = 2'b10
  } rscc_speed_t;
  localparam logic [1:0] RSCC_SEL_FACT = 2'b00;
  localparam logic [1:0] RSCC_SEL_400 = 2'b01;
  localparam logic [1:0] RSCC_SEL_266 = 2'b11;
  typedef enum logic [1:0] {
    RSCC_ST_RESET = 2'b00,
    RSCC_ST_CAPTURE = 2'b01,
    RSCC_ST_RUN = 2'b10
  } rscc_state_t;
endpackage

// [design/rscc_speed_limit.sv]
`timescale 1ns/1ps
module rscc_speed_limit
  import rscc_pkg::*;
(
  rscc_if.lim sp
);
  rscc_speed_t req;
  always_comb begin
    req = sp.fused;
    if (!sp.override_n) begin
      case (sp.sel)
        RSCC_SEL_400: req = RSCC_SPD_400;
        RSCC_SEL_266: req = RSCC_SPD_266;
        // pattern 10 is undefined, treat like 00
        default: req = sp.fused; // R10 R14
      endcase
    end
  end
  // codes are ordered, so the lower code is the slower clock
  assign sp.speed = (req < sp.fused) ? req : sp.fused; // R11
endmodule

// [design/rscc_top.sv]
`timescale 1ns/1ps
// How it works
// R1: in reset, release address pins and capture all 24 pins into register.
// R2: capture occurs on the first clock after synchronous reset release.
// R3: bits 23..21 read-only; other bits writable and readable by software.
// R4: every register bit drives a configuration output continuously.
// R5: bit 4 selects PCI speed, 0 for 33 MHz, 1 for 66 MHz.
// R6: bit 2 high enables the PCI arbiter.
// R7: bit 1 high makes PCI the bus host.
// R8: bit 0 selects flash width, 0 for 16-bit, 1 for 8-bit.
// R9: board keeps pin 3 high; software always writes bit 3 as one.
// R10: bit 23 low enables override; bits 22:21 pick factory, 400 or 266.
// R11: effective processor speed is never above the fused grade.
// R12: speed selection comes from pins 23..21 at reset release, held.
// R13: the external-bus clock samples the address pins.
// R14: override with undefined pattern 10 falls back to factory speed.
// R15: software writes persist until the next reset recaptures the pins.
module rscc_top
  import rscc_pkg::*;
(
  input wire logic ext_bus_clock,
  input wire logic reset_n,
  input wire logic [23:0] ext_bus_addr_pins_in,
  output logic [23:0] ext_bus_addr_pins_out,
  output logic [23:0] ext_bus_addr_pins_oe,
  input wire logic [23:0] bus_addr_out,
  input wire logic bus_addr_drive,
  input wire logic [1:0] fused_speed,
  input wire logic reg_sel,
  input wire logic [RSCC_ADDR_W-1:0] reg_addr,
  input wire logic reg_write,
  input wire logic [23:0] reg_wdata,
  output logic [23:0] reg_rdata,
  output logic [23:0] strap_config,
  output logic pci_66mhz,
  output logic arbiter_enable_strap,
  output logic pci_host,
  output logic flash_8bit,
  output logic speed_select_hi,
  output logic speed_select_lo,
  output logic speed_override_n,
  output logic [1:0] cpu_speed
);
  // ****************************************
  // pin sampling
  // ****************************************
  logic [23:0] pin_meta;
  logic [23:0] pin_sync;
  always_ff @(posedge ext_bus_clock) begin // R13
    pin_meta <= ext_bus_addr_pins_in;
    pin_sync <= pin_meta;
  end
  // ****************************************
  // capture sequencing
  // ****************************************
  rscc_state_t state;
  rscc_state_t next_state;
  always_comb begin
    case (state)
      RSCC_ST_RESET: next_state = RSCC_ST_CAPTURE;
      RSCC_ST_CAPTURE: next_state = RSCC_ST_RUN;
      RSCC_ST_RUN: next_state = RSCC_ST_RUN;
      default: next_state = RSCC_ST_RESET;
    endcase
  end
  always_ff @(posedge ext_bus_clock) begin
    if (!reset_n) begin
      state <= RSCC_ST_RESET;
    end else begin
      state <= next_state;
    end
  end
  state_walk_a: assert property ( // R2
    @(posedge ext_bus_clock) disable iff (!reset_n)
    state == RSCC_ST_CAPTURE |=> state == RSCC_ST_RUN)
    else $error("capture state did not move on to run");
  // pins stay released through reset and the capture edge
  always_comb begin
    ext_bus_addr_pins_out = bus_addr_out;
    if (state == RSCC_ST_RUN && bus_addr_drive) begin
      ext_bus_addr_pins_oe = 24'hffffff;
    end else begin
      ext_bus_addr_pins_oe = 24'h000000; // R1
    end
  end
  // a released pin shows only its strap, never the bus address
  pins_released_a: assert property ( // R1
    @(posedge ext_bus_clock)
    state != RSCC_ST_RUN |-> ext_bus_addr_pins_oe == 24'h000000)
    else $error("address pins driven during capture");
  drive_on_a: assert property ( // R1
    @(posedge ext_bus_clock) disable iff (!reset_n)
    state == RSCC_ST_RUN && bus_addr_drive
    |-> ext_bus_addr_pins_oe == 24'hffffff
    && ext_bus_addr_pins_out == bus_addr_out)
    else $error("address pins not driven in run");
  // ****************************************
  // configuration register
  // ****************************************
  logic wr_hit;
  assign wr_hit = reg_sel && reg_write && reg_addr == RSCC_OFS_CFG
                  && state == RSCC_ST_RUN;
  always_ff @(posedge ext_bus_clock) begin
    if (!reset_n) begin
      strap_config <= RSCC_RESET_VAL;
    end else if (state == RSCC_ST_RESET) begin
      strap_config <= pin_sync; // R1 R2 R12
    end else if (wr_hit) begin
      // top three bits keep the captured speed selection
      strap_config <= (strap_config & RSCC_RO_MASK)
                      | (reg_wdata & ~RSCC_RO_MASK); // R3 R15
    end
  end
  // capture takes the synchronised copy: straps settle two edges early
  reset_state_a: assert property ( // R1
    @(posedge ext_bus_clock)
    !reset_n |=> state == RSCC_ST_RESET && strap_config == RSCC_RESET_VAL
    && reg_rdata == 24'h000000)
    else $error("reset state not entered");
  capture_edge_a: assert property ( // R2
    @(posedge ext_bus_clock) disable iff (!reset_n)
    state == RSCC_ST_RESET |=> strap_config == $past(pin_sync))
    else $error("strap not captured after reset release");
  capture_once_a: assert property ( // R2
    @(posedge ext_bus_clock) disable iff (!reset_n)
    state == RSCC_ST_CAPTURE |=> $stable(strap_config))
    else $error("config changed in the capture cycle");
  ro_bits_a: assert property ( // R12
    @(posedge ext_bus_clock) disable iff (!reset_n)
    state == RSCC_ST_RUN && $past(state) == RSCC_ST_RUN
    |-> $stable(strap_config[23:21]))
    else $error("speed selection changed after capture");
  ro_write_a: assert property ( // R3
    @(posedge ext_bus_clock) disable iff (!reset_n)
    wr_hit |=> strap_config[23:21] == $past(strap_config[23:21]))
    else $error("read-only bits took write data");
  write_hit_a: assert property ( // R3
    @(posedge ext_bus_clock) disable iff (!reset_n)
    wr_hit |=> strap_config[20:0] == $past(reg_wdata[20:0]))
    else $error("writable bits not updated");
  persist_a: assert property ( // R15
    @(posedge ext_bus_clock) disable iff (!reset_n)
    state == RSCC_ST_RUN && !wr_hit |=> $stable(strap_config))
    else $error("config changed without a write");
  // ****************************************
  // register reads
  // ****************************************
  // a flop, so the word holds until the next read strobe
  always_ff @(posedge ext_bus_clock) begin
    if (!reset_n) begin
      reg_rdata <= 24'h000000;
    end else if (reg_sel && !reg_write) begin
      if (reg_addr == RSCC_OFS_CFG) begin
        reg_rdata <= strap_config; // R3
      end else begin
        reg_rdata <= 24'h000000;
      end
    end
  end
  read_back_a: assert property ( // R3
    @(posedge ext_bus_clock) disable iff (!reset_n)
    reg_sel && !reg_write && reg_addr == RSCC_OFS_CFG
    |=> reg_rdata == $past(strap_config))
    else $error("read data mismatch");
  unmapped_read_a: assert property ( // R3
    @(posedge ext_bus_clock) disable iff (!reset_n)
    reg_sel && !reg_write && reg_addr != RSCC_OFS_CFG
    |=> reg_rdata == 24'h000000)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property ( // R3
    @(posedge ext_bus_clock) disable iff (!reset_n)
    !(reg_sel && !reg_write) |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  // ****************************************
  // decoded outputs
  // ****************************************
  assign pci_66mhz = strap_config[RSCC_BIT_PCI66]; // R4 R5
  assign arbiter_enable_strap = strap_config[RSCC_BIT_ARB]; // R6
  assign pci_host = strap_config[RSCC_BIT_HOST]; // R7
  assign flash_8bit = strap_config[RSCC_BIT_FLASH8]; // R8
  assign speed_select_hi = strap_config[RSCC_BIT_SPD_HI];
  assign speed_select_lo = strap_config[RSCC_BIT_SPD_LO];
  assign speed_override_n = strap_config[RSCC_BIT_OVR_N];
  rscc_if sp ();
  assign sp.sel = {speed_select_hi, speed_select_lo}; // R10
  assign sp.override_n = speed_override_n;
  assign sp.fused = rscc_speed_t'(fused_speed);
  rscc_speed_limit i_rscc_speed_limit (
    .sp(sp)
  );
  assign cpu_speed = sp.speed; // R11
  // fused code 11 is unused and never caps a selection
  speed_cap_a: assert property ( // R11
    @(posedge ext_bus_clock) disable iff (!reset_n)
    cpu_speed <= fused_speed)
    else $error("processor speed above fused grade");
  no_override_a: assert property ( // R10 R14
    @(posedge ext_bus_clock) disable iff (!reset_n)
    speed_override_n || strap_config[22:21] == 2'h2
    |-> cpu_speed == fused_speed)
    else $error("factory speed not applied");
  sel_266_a: assert property ( // R10
    @(posedge ext_bus_clock) disable iff (!reset_n)
    !speed_override_n && strap_config[22:21] == RSCC_SEL_266
    |-> cpu_speed == RSCC_SPD_266)
    else $error("266 selection not applied");
  sel_400_a: assert property ( // R10 R11
    @(posedge ext_bus_clock) disable iff (!reset_n)
    !speed_override_n && strap_config[22:21] == RSCC_SEL_400
    && fused_speed != RSCC_SPD_266 |-> cpu_speed == RSCC_SPD_400)
    else $error("400 selection not applied");
  pci_bits_a: assert property ( // R4 R5 R6 R7 R8
    @(posedge ext_bus_clock) disable iff (!reset_n)
    {pci_66mhz, arbiter_enable_strap, pci_host, flash_8bit}
    == {strap_config[4], strap_config[2:0]})
    else $error("config outputs disagree with register");
  speed_bits_a: assert property ( // R4 R10
    @(posedge ext_bus_clock) disable iff (!reset_n)
    {speed_override_n, speed_select_hi, speed_select_lo}
    == strap_config[23:21])
    else $error("speed outputs disagree with register");
endmodule

// [test/rscc_straps.sv]
`timescale 1ns/1ps
module rscc_straps (
  input wire logic [23:0] pull_dn,
  input wire logic [23:0] dev_out,
  input wire logic [23:0] dev_oe,
  output logic [23:0] pins
);
  logic [23:0] strap;
  // weak pull-ups everywhere; the board never straps pin 3 low
  assign strap = ~pull_dn | 24'h000008;
  // a driven pin follows the device, a released one its resistor
  assign pins = (dev_oe & dev_out) | (~dev_oe & strap);
endmodule

// [test/rscc_tb_top.sv]
`timescale 1ns/1ps
module rscc_tb_top;
  import rscc_pkg::*;
  logic clk = 0, reset_n = 0, drive = 1, sel = 0, wr_en = 0;
  logic [23:0] pull_dn = 24'h0, pins, pin_out, oe, rdata, cfg, wdata = 24'h0;
  logic [23:0] addr_out = 24'h5a5a5a;
  logic [1:0] fused = 2'h2, cpu_speed;
  logic [RSCC_ADDR_W-1:0] addr = 2'h0;
  logic p66, arb, host, f8, s_hi, s_lo, ovr_n;
  logic [2:0] pat [5] = '{3'h4, 3'h0, 3'h1, 3'h3, 3'h2};
  int n_mismatch = 0, tests_run = 0, cyc = 0;
  rscc_top i_rscc_top (.ext_bus_clock(clk), .reset_n(reset_n),
    .ext_bus_addr_pins_in(pins), .ext_bus_addr_pins_out(pin_out),
    .ext_bus_addr_pins_oe(oe), .bus_addr_out(addr_out),
    .bus_addr_drive(drive), .fused_speed(fused), .reg_sel(sel),
    .reg_addr(addr), .reg_write(wr_en), .reg_wdata(wdata),
    .reg_rdata(rdata), .strap_config(cfg), .pci_66mhz(p66),
    .arbiter_enable_strap(arb), .pci_host(host), .flash_8bit(f8),
    .speed_select_hi(s_hi), .speed_select_lo(s_lo),
    .speed_override_n(ovr_n), .cpu_speed(cpu_speed));
  rscc_straps i_rscc_straps (.pull_dn(pull_dn), .dev_out(pin_out),
    .dev_oe(oe), .pins(pins));
  // ****************************************
  // clock, timeout, helpers
  // ****************************************
  initial forever #50 clk = ~clk;
  // about 150 cycles needed; generous ceiling
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // drive stays requested so the release during reset is really tested
  task do_reset(input logic [23:0] val);
    @(negedge clk);
    reset_n = 0;
    pull_dn = ~val;
    repeat (4) @(negedge clk);
    chk(oe, 24'h0);
    reset_n = 1;
    @(negedge clk);
    chk(oe, 24'h0);
    chk(cfg, val | 24'h8);
    @(negedge clk);
    chk(oe, 24'hffffff);
    chk(pin_out, addr_out);
  endtask
  task wr(input logic [1:0] a, input logic [23:0] d);
    @(negedge clk);
    sel = 1;
    wr_en = 1;
    addr = a;
    wdata = d;
    @(negedge clk);
    sel = 0;
    wr_en = 0;
  endtask
  task rd(input logic [1:0] a, output logic [23:0] d);
    @(negedge clk);
    sel = 1;
    addr = a;
    @(negedge clk);
    sel = 0;
    d = rdata;
  endtask
  function logic [1:0] exp_spd(input logic [1:0] f, input logic [2:0] p);
    logic [1:0] s;
    s = p[2] ? f : p[1:0] == 2'h1 ? 2'h1 : p[1:0] == 2'h3 ? 2'h0 : f;
    return s < f ? s : f;
  endfunction
  // ****************************************
  // tests
  // ****************************************
  initial begin
    logic [23:0] v, r;
    v = 24'h0a5a17;
    for (int k = 0; k < 2; k++) begin
      do_reset(v);
      r = v | 24'h8;
      chk({21'h0, ovr_n, s_hi, s_lo}, {21'h0, r[23:21]});
      chk({20'h0, p66, arb, host, f8}, {20'h0, r[4], r[2:0]});
      v = ~v;
    end
    $display("test capture done");
    r = {r[23:21], 21'h15aa5c};
    wr(RSCC_OFS_CFG, 24'h15aa5c);
    chk(cfg, r);
    wr(2'h1, 24'h0);
    rd(RSCC_OFS_CFG, v);
    chk(v, r);
    rd(2'h1, v);
    chk(v, 24'h0);
    repeat (5) @(negedge clk);
    chk(cfg, r);
    drive = 0;
    @(negedge clk);
    chk(oe, 24'h0);
    drive = 1;
    do_reset(24'h00ffff);
    $display("test register done");
    for (int f = 0; f < 3; f++) begin
      for (int p = 0; p < 5; p++) begin
        fused = f[1:0];
        do_reset({pat[p], 21'h1fffff});
        chk({22'h0, cpu_speed},
          {22'h0, exp_spd(f[1:0], pat[p])});
      end
    end
    $display("test speed done");
    tally_and_finish();
  end
endmodule
